//--- acc_regs.vh
/*
  register map and timing constants of the converter control block.
  assumes a 32-bit axi4-lite slave, byte addresses, one word per register.
*/
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

`define ACC_OFF_MAIN 8'h00
`define ACC_OFF_INPUT 8'h04
`define ACC_OFF_TIMING 8'h08
`define ACC_OFF_SCANLO 8'h0C
`define ACC_OFF_STATUS 8'h10
`define ACC_OFF_MASK 8'h14
`define ACC_OFF_ANSEL 8'h18
`define ACC_OFF_DIR 8'h1C
`define ACC_OFF_LAT 8'h20
`define ACC_OFF_PORT 8'h24
`define ACC_OFF_RESULT 8'h28

`define ACC_MAIN_ON 15
`define ACC_MAIN_RES12 10
`define ACC_MAIN_START 1
`define ACC_MAIN_TRIG_HI 7
`define ACC_MAIN_TRIG_LO 4
`define ACC_INPUT_UREF_HI 15
`define ACC_INPUT_UREF_LO 14
`define ACC_INPUT_LREF 13
`define ACC_INPUT_CH_HI 4
`define ACC_INPUT_CH_LO 0
`define ACC_TIMING_RC 15
`define ACC_TIMING_DIV_HI 5
`define ACC_TIMING_DIV_LO 0

`define ACC_STAT_DONE 0
`define ACC_STAT_LOCKWR 1

`define ACC_MAIN_RST 16'h0000
`define ACC_INPUT_RST 16'h0000
`define ACC_TIMING_RST 16'h0000
`define ACC_ANSEL_RST 16'hFFFF
`define ACC_DIR_RST 16'hFFFF

`define ACC_PERIODS_12 5'd14
`define ACC_PERIODS_10 5'd12

`endif

//--- acc_result_mem.v
/*
  result store: one word per channel, registered read port.
  assumes writer and reader share ref_clk; contents survive disable.
*/
`timescale 1ns/1ns
module acc_result_mem #(
  parameter AW = 4,
  parameter DW = 12
) (
  input wire ref_clk,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [DW-1:0] wrData,
  input wire [AW-1:0] rdAddr,
  output reg [DW-1:0] rdData
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // acc_result_mem

//--- acc_converter_ctrl.v
/*
  converter control: axi4-lite registers, conversion clock, conversion
  sequencing, reference select, analog pin and port logic, interrupt.
  assumes ref_clk is the instruction clock and rcClkTick a one-cycle
  pulse per rc oscillator period, synchronous to ref_clk.
*/
// Overview of operation
// - resolution select set gives 12-bit results, else 10-bit
// - conversion lasts 14 clock periods at 12-bit, 12 at 10-bit
// - clock period is instruction period times divider select plus one
// - rc clock select uses rc oscillator, divider select ignored
// - 2-bit upper reference select, 1-bit lower reference select
// - pins shared with external references still convert as analog channels
// - analog select bit makes pin analog; analog after reset
// - all direction bits set after reset, pins inputs
// - analog pin driven as output converts the driven output level
// - port reads return zero for analog pins
// - converter works only while on; registers and results retained
`timescale 1ns/1ns
`include "acc_regs.vh"
module acc_converter_ctrl #(
  parameter NPINS = 16,
  parameter DIVW = 6
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rcClkTick,
  input wire [NPINS-1:0] pinIn,
  input wire [11:0] sarCode,
  output reg [NPINS-1:0] pinOut,
  output reg [NPINS-1:0] pinOe,
  output reg [NPINS-1:0] digInEn,
  output reg [NPINS-1:0] anaSwitch,
  output reg [1:0] upperRefSel,
  output reg lowerRefSel,
  output reg analogPowered,
  output reg convClk,
  output reg converting,
  output reg irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CONV = 2'd1;
  localparam ST_DONE = 2'd2;

  reg [15:0] mainCtl_r;
  reg [15:0] inputCtl_r;
  reg [15:0] timingCtl_r;
  reg [15:0] scanLo_r;
  reg [1:0] status_r;
  reg [1:0] mask_r;
  reg [NPINS-1:0] anaSel_r;
  reg [NPINS-1:0] dir_r;
  reg [NPINS-1:0] lat_r;
  reg [1:0] state_r;
  reg [DIVW-1:0] divCnt_r;
  reg [4:0] periodCnt_r;
  reg startReq_r;
  reg awHeld_r;
  reg wHeld_r;
  reg [7:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg rdPend_r;
  reg [7:0] arAddr_r;
  reg [11:0] sample_r;

  wire convOn = mainCtl_r[`ACC_MAIN_ON];
  wire res12 = mainCtl_r[`ACC_MAIN_RES12];
  wire [DIVW-1:0] divSel = timingCtl_r[`ACC_TIMING_DIV_HI:`ACC_TIMING_DIV_LO];
  wire rcSel = timingCtl_r[`ACC_TIMING_RC];
  wire [3:0] chSel = inputCtl_r[3:0];
  wire [11:0] memRd;

  // conversion clock tick, one per conversion clock period
  wire divWrap = (divCnt_r == divSel);
  wire tadTick = rcSel ? rcClkTick : divWrap;

  always @(posedge ref_clk) begin
    if (!rst_b || !convOn || rcSel) begin
      divCnt_r <= {DIVW{1'b0}};
    end else if (divWrap) begin
      divCnt_r <= {DIVW{1'b0}};
    end else begin
      divCnt_r <= divCnt_r + 1'b1;
    end
  end

  // write channel: address and data taken in either order
  wire wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire wrHit = wrFire;
  wire [15:0] wd = wData_r[15:0];
  wire [15:0] wMask = {{8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  wire lockedWrite = convOn && wrHit &&
    (awAddr_r == `ACC_OFF_TIMING || awAddr_r == `ACC_OFF_SCANLO);
  wire mapped = (awAddr_r <= `ACC_OFF_PORT) && (awAddr_r[1:0] == 2'b00);

  wire convEnd = convOn && (state_r == ST_CONV) && tadTick &&
    (periodCnt_r == (res12 ? `ACC_PERIODS_12 : `ACC_PERIODS_10) - 5'd1);

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      mainCtl_r <= `ACC_MAIN_RST;
      inputCtl_r <= `ACC_INPUT_RST;
      timingCtl_r <= `ACC_TIMING_RST;
      scanLo_r <= 16'h0000;
      mask_r <= 2'b00;
      status_r <= 2'b00;
      anaSel_r <= `ACC_ANSEL_RST;
      dir_r <= `ACC_DIR_RST;
      lat_r <= {NPINS{1'b0}};
      startReq_r <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      startReq_r <= 1'b0;
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped ? 2'b00 : 2'b10;
        case (awAddr_r)
          `ACC_OFF_MAIN: begin
            mainCtl_r <= (mainCtl_r & ~wMask) | (wd & wMask & 16'hFFFD);
            startReq_r <= wStrb_r[0] && wd[`ACC_MAIN_START];
          end
          `ACC_OFF_INPUT: inputCtl_r <= (inputCtl_r & ~wMask) | (wd & wMask);
          `ACC_OFF_TIMING: begin
            if (!convOn) begin
              timingCtl_r <= (timingCtl_r & ~wMask) | (wd & wMask);
            end
          end
          `ACC_OFF_SCANLO: begin
            if (!convOn) begin
              scanLo_r <= (scanLo_r & ~wMask) | (wd & wMask);
            end
          end
          `ACC_OFF_MASK: mask_r <= wd[1:0];
          `ACC_OFF_ANSEL: anaSel_r <= (anaSel_r & ~wMask) | (wd & wMask);
          `ACC_OFF_DIR: dir_r <= (dir_r & ~wMask) | (wd & wMask);
          `ACC_OFF_LAT: lat_r <= (lat_r & ~wMask) | (wd & wMask);
          default: ;
        endcase
      end
      // sticky events: set wins over write-one-to-clear
      status_r[`ACC_STAT_DONE] <= convEnd ||
        (status_r[`ACC_STAT_DONE] &&
         !(wrHit && awAddr_r == `ACC_OFF_STATUS && wd[`ACC_STAT_DONE]));
      status_r[`ACC_STAT_LOCKWR] <= lockedWrite ||
        (status_r[`ACC_STAT_LOCKWR] &&
         !(wrHit && awAddr_r == `ACC_OFF_STATUS && wd[`ACC_STAT_LOCKWR]));
    end
  end

  // converter sequencing
  wire [3:0] resAddr = chSel;
  // memory read starts at the address handshake, so data stand when rvalid rises
  wire [7:0] rdSel = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : arAddr_r;
  wire [7:0] rdOff = rdSel - `ACC_OFF_RESULT;
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      periodCnt_r <= 5'd0;
      sample_r <= 12'h000;
    end else if (!convOn) begin
      state_r <= ST_IDLE;
      periodCnt_r <= 5'd0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          periodCnt_r <= 5'd0;
          if (startReq_r) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (convEnd) begin
            state_r <= ST_DONE;
            // 10-bit mode keeps only the upper ten code bits
            sample_r <= res12 ? sarCode : {2'b00, sarCode[11:2]};
          end else if (tadTick) begin
            periodCnt_r <= periodCnt_r + 5'd1;
          end
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  acc_result_mem #(
    .AW(4),
    .DW(12)
  ) u_mem (
    .ref_clk(ref_clk),
    .wrEn(state_r == ST_DONE),
    .wrAddr(resAddr),
    .wrData(sample_r),
    .rdAddr(rdOff[5:2]),
    .rdData(memRd)
  );

  // read channel; result word read from memory in the same cycle as address capture
  wire [NPINS-1:0] portRd = pinIn & ~anaSel_r;
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      rdPend_r <= 1'b0;
      arAddr_r <= 8'h00;
    end else begin
      s_axi_arready <= !rdPend_r && !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rdPend_r <= 1'b1;
        arAddr_r <= s_axi_araddr;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rdPend_r) begin
        rdPend_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (arAddr_r)
          `ACC_OFF_MAIN: s_axi_rdata <= {16'h0000, mainCtl_r};
          `ACC_OFF_INPUT: s_axi_rdata <= {16'h0000, inputCtl_r};
          `ACC_OFF_TIMING: s_axi_rdata <= {16'h0000, timingCtl_r};
          `ACC_OFF_SCANLO: s_axi_rdata <= {16'h0000, scanLo_r};
          `ACC_OFF_STATUS: s_axi_rdata <= {29'h0, converting, status_r};
          `ACC_OFF_MASK: s_axi_rdata <= {30'h0, mask_r};
          `ACC_OFF_ANSEL: s_axi_rdata <= {{(32-NPINS){1'b0}}, anaSel_r};
          `ACC_OFF_DIR: s_axi_rdata <= {{(32-NPINS){1'b0}}, dir_r};
          `ACC_OFF_LAT: s_axi_rdata <= {{(32-NPINS){1'b0}}, lat_r};
          `ACC_OFF_PORT: s_axi_rdata <= {{(32-NPINS){1'b0}}, portRd};
          default: begin
            if (arAddr_r >= `ACC_OFF_RESULT && arAddr_r < `ACC_OFF_RESULT + 8'h40) begin
              s_axi_rdata <= {20'h00000, memRd};
            end else begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= 2'b10;
            end
          end
        endcase
      end
    end
  end

  // pins, references, power and interrupt outputs
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      pinOut <= {NPINS{1'b0}};
      pinOe <= {NPINS{1'b0}};
      digInEn <= {NPINS{1'b0}};
      anaSwitch <= {NPINS{1'b0}};
      upperRefSel <= 2'b00;
      lowerRefSel <= 1'b0;
      analogPowered <= 1'b0;
      convClk <= 1'b0;
      converting <= 1'b0;
      irq <= 1'b0;
    end else begin
      pinOut <= lat_r;
      // output driver stays on for analog pins, so its level is converted
      pinOe <= ~dir_r;
      digInEn <= ~anaSel_r;
      // reference-shared pins are not excluded from the analog switch
      anaSwitch <= anaSel_r;
      upperRefSel <= inputCtl_r[`ACC_INPUT_UREF_HI:`ACC_INPUT_UREF_LO];
      lowerRefSel <= inputCtl_r[`ACC_INPUT_LREF];
      analogPowered <= convOn;
      convClk <= convOn && tadTick;
      converting <= convOn && (state_r == ST_CONV);
      irq <= |(status_r & mask_r);
    end
  end
endmodule // acc_converter_ctrl

//--- acc_converter_ctrl_checker.sv
/*
  port-level checker for the converter control block.
  assumes it is bound to acc_converter_ctrl, one clock, sync active-low reset.
*/
`timescale 1ns/1ns
module acc_converter_ctrl_checker #(
  parameter NPINS = 16
) (
  input wire ref_clk,
  input wire rst_b,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NPINS-1:0] anaSwitch,
  input wire [NPINS-1:0] digInEn,
  input wire analogPowered,
  input wire convClk,
  input wire converting
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_arTaken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_dataBack; ##2 s_axi_rvalid; endsequence
  property p_offNoClk; !analogPowered |-> !convClk; endproperty
  a_offNoClk: assert property (p_offNoClk) else $error("tick while off");
  property p_offIdle; !analogPowered |-> !converting; endproperty
  a_offIdle: assert property (p_offIdle) else $error("busy while off");
  property p_convOn; $rose(converting) |-> analogPowered; endproperty
  a_convOn: assert property (p_convOn) else $error("start while off");
  property p_anaPair; $past(rst_b, 2) |-> anaSwitch == ~digInEn; endproperty
  a_anaPair: assert property (p_anaPair) else $error("switch and buffer disagree");
  property p_rLat; s_arTaken |-> s_dataBack; endproperty
  a_rLat: assert property (p_rLat) else $error("read data late");
  property p_arOne; s_axi_arready |=> !s_axi_arready; endproperty
  a_arOne: assert property (p_arOne) else $error("arready too long");
  property p_awOne; s_axi_awready |=> !s_axi_awready; endproperty
  a_awOne: assert property (p_awOne) else $error("awready too long");
  property p_bClr; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bClr: assert property (p_bClr) else $error("bvalid stuck");
  property p_rClr; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rClr: assert property (p_rClr) else $error("rvalid stuck");
endmodule // acc_converter_ctrl_checker

//--- tb_adc_config_and_conversion_clock.sv
/*
  self-checking bench for the converter control block.
  assumes acc_regs.vh offsets and the design's axi4-lite slave timing.
*/
`timescale 1ns/1ns
`include "acc_regs.vh"
module tb_adc_config_and_conversion_clock;
  logic ref_clk = 0, rst_b = 0, rcRun = 0, rcClkTick = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, lowerRefSel, analogPowered, convClk, converting, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, upperRefSel, rs, bs;
  logic [15:0] pinIn = 16'h0000, pinOut, pinOe, digInEn, anaSwitch;
  logic [11:0] sarCode = 12'habc;
  int mismatches = 0, comparisons = 0, rcCnt = 0;
  always #2 ref_clk = ~ref_clk;
  // rc oscillator stand-in: one pulse every 7 cycles
  always @(posedge ref_clk) begin
    rcCnt <= (rcCnt == 6) ? 0 : rcCnt + 1;
    rcClkTick <= rcRun && rcCnt == 6;
  end
  acc_converter_ctrl acc_converter_ctrl_inst (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rcClkTick, .pinIn, .sarCode, .pinOut, .pinOe,
    .digInEn, .anaSwitch, .upperRefSel, .lowerRefSel, .analogPowered, .convClk, .converting,
    .irq);
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    bs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0;
  endtask
  task gap(input int e);
    int n;
    n = 0;
    while (!convClk && n < 500) begin @(posedge ref_clk); n++; end
    n = 0;
    do begin @(posedge ref_clk); n++; end while (!convClk && n < 500);
    chk(n, e);
  endtask
  task t_pins;
    rdr(`ACC_OFF_ANSEL); chk(rd, 32'h0000_ffff);
    rdr(`ACC_OFF_DIR); chk(rd, 32'h0000_ffff);
    chk(pinOe, 16'h0000);
    chk(anaSwitch, 16'hffff);
    pinIn <= 16'ha5a5;
    wr(`ACC_OFF_ANSEL, 32'h0000_00ff);
    rdr(`ACC_OFF_PORT); chk(rd, 32'h0000_a500);
    chk(digInEn, 16'hff00);
    wr(`ACC_OFF_LAT, 32'h0000_0003);
    wr(`ACC_OFF_DIR, 32'h0000_fffe);
    @(posedge ref_clk);
    chk({pinOe[0], pinOut[0], anaSwitch[0]}, 3'b111);
    rdr(8'hfc); chk(rs, 2'b10);
    chk(rd, 32'h0000_0000);
    wr(8'hfc, 32'h0000_0000); chk(bs, 2'b10);
    $display("pins test done");
  endtask
  task conv(input logic res, input logic [5:0] dv, input logic [31:0] er);
    int n, k;
    wr(`ACC_OFF_TIMING, {26'h0, dv});
    wr(`ACC_OFF_INPUT, 32'h0000_a000);
    wr(`ACC_OFF_MASK, 32'h0000_0001);
    wr(`ACC_OFF_STATUS, 32'h0000_0003);
    wr(`ACC_OFF_MAIN, 32'h0000_8000 | {res, 10'h000});
    chk({upperRefSel, lowerRefSel}, 3'b101);
    gap(dv + 1);
    wr(`ACC_OFF_MAIN, 32'h0000_8002 | {res, 10'h000});
    k = 0; n = 0;
    while (!converting && k < 50) begin @(posedge ref_clk); k++; end
    while (converting && k < 5000) begin
      if (convClk) n++;
      @(posedge ref_clk);
      k++;
    end
    chk(n, res ? 14 : 12);
    rdr(`ACC_OFF_RESULT); chk(rd, er);
    chk(irq, 1'b1);
    wr(`ACC_OFF_STATUS, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    $display("conversion test done");
  endtask
  task t_lock;
    wr(`ACC_OFF_TIMING, 32'h0000_0002);
    wr(`ACC_OFF_MAIN, 32'h0000_8000);
    wr(`ACC_OFF_TIMING, 32'h0000_003f); chk(bs, 2'b00);
    rdr(`ACC_OFF_TIMING); chk(rd, 32'h0000_0002);
    rdr(`ACC_OFF_STATUS); chk(rd[1], 1'b1);
    wr(`ACC_OFF_MAIN, 32'h0000_0000);
    rdr(`ACC_OFF_INPUT); chk(rd, 32'h0000_a000);
    chk(analogPowered, 1'b0);
    $display("lock test done");
  endtask
  task t_rc;
    rcRun <= 1;
    wr(`ACC_OFF_TIMING, 32'h0000_8005);
    wr(`ACC_OFF_MAIN, 32'h0000_8000);
    gap(7);
    wr(`ACC_OFF_MAIN, 32'h0000_0000);
    $display("rc clock test done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1;
    t_pins;
    conv(1'b1, 6'd3, 32'h0000_0abc);
    wr(`ACC_OFF_MAIN, 32'h0000_0000);
    conv(1'b0, 6'd0, 32'h0000_02af);
    wr(`ACC_OFF_MAIN, 32'h0000_0000);
    t_lock;
    t_rc;
    test_done;
  end
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
endmodule // tb_adc_config_and_conversion_clock
bind acc_converter_ctrl acc_converter_ctrl_checker #(.NPINS(NPINS)) acc_converter_ctrl_checker_inst (
  .ref_clk, .rst_b, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .anaSwitch, .digInEn, .analogPowered,
  .convClk, .converting);
